//--- logic/biop_port.sv
// general purpose bidirectional io port with avalon-mm register slave
`timescale 1ns/100ps
`default_nettype none
module biop_port (
  input wire logic clock,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [biop_pkg::BIOP_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [biop_pkg::BIOP_DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [biop_pkg::BIOP_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup,
  // alternate function overrides, per pin
  input wire logic [7:0] alt_enable,
  input wire logic [7:0] alt_drive_en,
  input wire logic [7:0] alt_value,
  // sleep clamp
  input wire logic deep_sleep,
  input wire logic [7:0] clamp_exempt
);
  import biop_pkg::*;

  typedef struct packed {
    biop_byte_t direction;
    biop_byte_t output_latch;
    logic global_pullup_disable;
    logic ack;
    logic [31:0] rdata;
  } biop_state_s;

  biop_state_s st_q;
  biop_state_s st_d;
  biop_sync_if sif ();
  logic req;
  logic take;
  logic lane0;

  ////////////////////////////////////////////////////////////////////
  // input path, clamped in deep sleep ahead of the synchroniser
  assign sif.raw = deep_sleep ? (pin_in & clamp_exempt) : pin_in;

  biop_sync u_sync (
    .clock(clock),
    .nrst(nrst),
    .sif(sif)
  );

  ////////////////////////////////////////////////////////////////////
  // bus: one wait cycle, so every access answers on its second cycle
  assign req = avs_read | avs_write;
  assign take = req & st_q.ack;
  assign lane0 = avs_byteenable[0];
  assign avs_waitrequest = req & ~st_q.ack;
  assign avs_readdata = st_q.rdata;

  always_comb begin
    st_d = st_q;
    st_d.ack = req & ~st_q.ack;
    st_d.rdata = BIOP_RDATA_ZERO;
    if (avs_read & ~st_q.ack) begin
      unique case (avs_address)
        BIOP_OFS_INPUT_SAMPLE: st_d.rdata[7:0] = sif.sampled;
        BIOP_OFS_DIRECTION: st_d.rdata[7:0] = st_q.direction;
        BIOP_OFS_OUTPUT_LATCH: st_d.rdata[7:0] = st_q.output_latch;
        BIOP_OFS_MCU_CONTROL: st_d.rdata[BIOP_PUD_BIT] = st_q.global_pullup_disable;
        default: st_d.rdata = BIOP_RDATA_ZERO;
      endcase
    end
    if (avs_write & take & lane0) begin
      unique case (avs_address)
        // toggles regardless of direction; zeros leave bits alone
        BIOP_OFS_INPUT_SAMPLE: st_d.output_latch = st_q.output_latch ^ avs_writedata[7:0];
        BIOP_OFS_DIRECTION: st_d.direction = avs_writedata[7:0];
        BIOP_OFS_OUTPUT_LATCH: st_d.output_latch = avs_writedata[7:0];
        BIOP_OFS_MCU_CONTROL: st_d.global_pullup_disable = avs_writedata[BIOP_PUD_BIT];
        BIOP_OFS_DIR_SET: st_d.direction = st_q.direction | avs_writedata[7:0];
        BIOP_OFS_DIR_CLR: st_d.direction = st_q.direction & ~avs_writedata[7:0];
        BIOP_OFS_LATCH_SET: st_d.output_latch = st_q.output_latch | avs_writedata[7:0];
        BIOP_OFS_LATCH_CLR: st_d.output_latch = st_q.output_latch & ~avs_writedata[7:0];
        default: st_d.global_pullup_disable = st_q.global_pullup_disable;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_q <= '{direction: BIOP_RST_DIRECTION, output_latch: BIOP_RST_OUTPUT_LATCH,
                global_pullup_disable: BIOP_RST_PUD, ack: 1'h0, rdata: BIOP_RDATA_ZERO};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin drivers; reset gates enables directly so no clock is needed
  genvar gp;
  generate
    for (gp = 0; gp < BIOP_PINS; gp++) begin : g_pin
      always_comb begin
        if (!nrst) begin
          pin_oe[gp] = 1'h0;
          pin_pullup[gp] = 1'h0;
          pin_out[gp] = 1'h0;
        end else if (alt_enable[gp]) begin
          // override limited to this pin only
          pin_oe[gp] = alt_drive_en[gp];
          pin_out[gp] = alt_value[gp];
          pin_pullup[gp] = 1'h0;
        end else begin
          pin_oe[gp] = st_q.direction[gp];
          pin_out[gp] = st_q.output_latch[gp];
          pin_pullup[gp] = ~st_q.direction[gp] & st_q.output_latch[gp] & ~st_q.global_pullup_disable;
        end
      end
    end
  endgenerate
endmodule : biop_port
`default_nettype wire

//--- logic/biop_pkg.sv
// shared constants for the bidirectional io port
package biop_pkg;
  localparam int BIOP_PINS = 8;
  localparam int BIOP_AW = 5;
  localparam int BIOP_DW = 32;
  // register byte offsets
  localparam logic [4:0] BIOP_OFS_INPUT_SAMPLE = 5'h00;
  localparam logic [4:0] BIOP_OFS_DIRECTION = 5'h04;
  localparam logic [4:0] BIOP_OFS_OUTPUT_LATCH = 5'h08;
  localparam logic [4:0] BIOP_OFS_MCU_CONTROL = 5'h0C;
  localparam logic [4:0] BIOP_OFS_DIR_SET = 5'h10;
  localparam logic [4:0] BIOP_OFS_DIR_CLR = 5'h14;
  localparam logic [4:0] BIOP_OFS_LATCH_SET = 5'h18;
  localparam logic [4:0] BIOP_OFS_LATCH_CLR = 5'h1C;
  // control register field
  localparam int BIOP_PUD_BIT = 4;
  // reset values
  localparam logic [7:0] BIOP_RST_DIRECTION = 8'h00;
  localparam logic [7:0] BIOP_RST_OUTPUT_LATCH = 8'h00;
  localparam logic BIOP_RST_PUD = 1'h0;
  localparam logic [31:0] BIOP_RDATA_ZERO = 32'h0000_0000;
  localparam logic [7:0] BIOP_BYTE_ZERO = 8'h00;
  typedef logic [7:0] biop_byte_t;
endpackage : biop_pkg

//--- logic/biop_sync_if.sv
// carrier between the port core and its input synchroniser
`timescale 1ns/100ps
`default_nettype none
interface biop_sync_if;
  logic [7:0] raw;
  logic [7:0] sampled;
  modport core (output raw, input sampled);
  modport sync (input raw, output sampled);
endinterface : biop_sync_if
`default_nettype wire

//--- logic/biop_sync.sv
// two-stage input synchroniser: clock-high transparent latch then flop
`timescale 1ns/100ps
`default_nettype none
module biop_sync (
  input wire logic clock,
  input wire logic nrst,
  biop_sync_if.sync sif
);
  import biop_pkg::*;

  typedef struct packed {
    biop_byte_t sample;
  } biop_sync_s;

  biop_byte_t hold_lat;
  biop_sync_s st_q;
  biop_sync_s st_d;

  ////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < BIOP_PINS; gi++) begin : g_lat
      // open while clock high, closed while low
      always_latch begin
        if (clock) begin
          hold_lat[gi] = sif.raw[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    st_d.sample = hold_lat;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_q <= '{sample: BIOP_BYTE_ZERO};
    end else begin
      st_q <= st_d;
    end
  end

  assign sif.sampled = st_q.sample;
endmodule : biop_sync
`default_nettype wire

//--- testbench/biop_pins_model.sv
// external circuitry at the port pins
`timescale 1ns/100ps
`default_nettype none
module biop_pins_model (
  input wire logic clock,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  logic [7:0] flt_q = 8'h55;
  // a floating line wanders, so a stale level never reads as valid
  always @(posedge clock) flt_q <= ~flt_q;
  assign pin_in = pin_oe & pin_out | ~pin_oe & (ext_en & ext_val | ~ext_en & (pin_pullup | flt_q));
endmodule : biop_pins_model
`default_nettype wire

//--- testbench/biop_port_chk.sv
// assertions on the io port pins and register bus
`timescale 1ns/100ps
`default_nettype none
module biop_port_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] alt_enable,
  input wire logic [7:0] alt_drive_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  chk_reset_quiet: assert property (disable iff (1'h0) !nrst |-> !(pin_oe | pin_pullup | pin_out))
    else $error("pins active in reset");
  chk_one_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait cycle count wrong");
  chk_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait without request");
  chk_upper_zero: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data above byte");
  chk_out_nopull: assert property ((pin_oe & pin_pullup) == 8'h00)
    else $error("pull-up on driven pin");
  chk_dir_hold: assert property (!(avs_write && !avs_waitrequest) ##1 $stable(alt_enable) && $stable(alt_drive_en) |-> $stable(pin_oe))
    else $error("direction moved unwritten");
  chk_alt_pull: assert property ((pin_pullup & alt_enable) == 8'h00)
    else $error("pull-up on override pin");
  chk_alt_drive: assert property (((pin_oe ^ alt_drive_en) & alt_enable) == 8'h00)
    else $error("override drive ignored");
  cover property (avs_read && !avs_waitrequest);
  cover property (avs_write && !avs_waitrequest);
  cover property (alt_enable != 8'h00);
endmodule : biop_port_chk
bind biop_port biop_port_chk chk_i (.*);
`default_nettype wire

//--- testbench/test_biop_port.sv
// self-checking bench for the io port
`timescale 1ns/100ps
`default_nettype none
module test_biop_port;
  import biop_pkg::*;
  logic clock = 0, nrst = 0, rd = 0, wr = 0, slp = 0, wq;
  logic [4:0] adr = 0;
  logic [31:0] wd = 0, rdat, q;
  logic [7:0] pout, poe, ppu, pin, aen = 0, ext = 8'hA5, exe = 8'hFF, cex = 0;
  int err_count = 0, num_checks = 0;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch t=%0t got %h", $time, a); end end
  biop_port uut (.clock, .nrst, .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wq),
    .pin_in(pin), .pin_out(pout), .pin_oe(poe), .pin_pullup(ppu), .alt_enable(aen),
    .alt_drive_en(aen), .alt_value(aen), .deep_sleep(slp), .clamp_exempt(cex));
  biop_pins_model far_side (.clock, .pin_out(pout), .pin_oe(poe), .pin_pullup(ppu),
    .ext_en(exe), .ext_val(ext), .pin_in(pin));
  initial forever #10 clock = ~clock;
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    {wr, rd, adr, wd} <= {w, ~w, a, 24'h0, d};
    // request stands until the edge that sees waitrequest low; data taken there
    do @(posedge clock); while (wq !== 1'h0);
    q = rdat;
    {wr, rd} <= 2'h0;
  endtask : bus
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    bus(0, a, 8'h00);
    `CHK(q, {24'h0, e})
  endtask : rchk
  task automatic t_reset;
    @(negedge clock) `CHK({poe, ppu, pout}, 24'h0)
    repeat (8) @(posedge clock);
    nrst <= 1;
    rchk(BIOP_OFS_DIRECTION, 8'h00);
    rchk(BIOP_OFS_OUTPUT_LATCH, 8'h00);
  endtask : t_reset
  task automatic t_pull;
    exe <= 8'hF0;
    bus(1, BIOP_OFS_OUTPUT_LATCH, 8'h0F);
    @(negedge clock) `CHK(ppu, 8'h0F)
    bus(1, BIOP_OFS_MCU_CONTROL, 8'h10);
    @(negedge clock) `CHK(ppu, 8'h00)
    rchk(BIOP_OFS_MCU_CONTROL, 8'h10);
    bus(1, BIOP_OFS_MCU_CONTROL, 8'h00);
    // pins 2 and 3 reach output high by way of pull-up input
    bus(1, BIOP_OFS_DIRECTION, 8'h3C);
    @(negedge clock) `CHK({poe, pout & poe, ppu}, 24'h3C0C03)
    rchk(BIOP_OFS_INPUT_SAMPLE, 8'h8F);
    rchk(5'h01, 8'h00);
  endtask : t_pull
  task automatic t_bits;
    bus(1, BIOP_OFS_INPUT_SAMPLE, 8'h81);
    rchk(BIOP_OFS_OUTPUT_LATCH, 8'h8E);
    // each step moves one pin: tri-state to low, high to low, low to tri-state, tri-state to pull-up; never pull-up to low
    bus(1, BIOP_OFS_DIR_SET, 8'h01);
    bus(1, BIOP_OFS_LATCH_CLR, 8'h08);
    bus(1, BIOP_OFS_DIR_CLR, 8'h20);
    bus(1, BIOP_OFS_LATCH_SET, 8'h40);
    rchk(BIOP_OFS_DIRECTION, 8'h1D);
    rchk(BIOP_OFS_OUTPUT_LATCH, 8'hC6);
  endtask : t_bits
  task automatic t_alt;
    @(posedge clock) aen <= 8'h40;
    @(negedge clock) `CHK(poe, 8'h5D)
    @(posedge clock) {slp, cex} <= {1'b1, 8'h04};
    repeat (3) @(posedge clock);
    rchk(BIOP_OFS_INPUT_SAMPLE, 8'h04);
  endtask : t_alt
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (2000) @(posedge clock);
    err_count++;
    finish_test();
  end
  initial begin
    t_reset();
    t_pull();
    t_bits();
    t_alt();
    finish_test();
  end
endmodule : test_biop_port
`default_nettype wire
